// File: src/pcm_acc_if.sv
`timescale 1ns/100ps
interface pcm_acc_if;
  import pcm_pkg::*;
  logic tick;
  logic active;
  logic rationing_enable_bit;
  logic rtn_clr;
  logic [CUR_W-1:0] sample;
  logic [ACC_W-1:0] threshold;
  logic [ACC_W-1:0] total;
  logic thr_hit;
  modport ctl (output active, output rationing_enable_bit, output rtn_clr, output sample,
               output threshold, input tick, input total, input thr_hit);
  modport acc (input tick, input active, input rationing_enable_bit, input rtn_clr, input sample,
               input threshold, output total, output thr_hit);
  modport tck (output tick);
endinterface

// File: src/pcm_charge_acc.sv
`timescale 1ns/100ps
module pcm_charge_acc (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control and result
  pcm_acc_if.acc a
);
  import pcm_pkg::*;

  logic [ACC_W-1:0] total_r;
  logic [ACC_W:0] sum;
  logic upd_r;
  logic hit_r;

  // One count of current held one second is almost exactly one charge count
  assign sum = {1'b0, total_r} + (ACC_W+1)'(a.sample);

  // Total only returns to zero from software; saturates instead of wrapping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      total_r <= '0;
    end else if (a.rtn_clr || !a.rationing_enable_bit) begin
      total_r <= '0;
    end else if (a.tick && a.active) begin
      total_r <= sum[ACC_W] ? '1 : sum[ACC_W-1:0];
    end
  end

  // Compare the fresh total once after each update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upd_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      upd_r <= a.tick && a.active && a.rationing_enable_bit && !a.rtn_clr;
      hit_r <= upd_r && (total_r >= a.threshold);
    end
  end

  assign a.total = total_r;
  assign a.thr_hit = hit_r;

endmodule

// File: src/pcm_pkg.sv
package pcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is index times four
  localparam logic [IDX_W-1:0] IDX_CURRENT = 6'h00;
  localparam logic [IDX_W-1:0] IDX_ACC3 = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ACC2 = 6'h02;
  localparam logic [IDX_W-1:0] IDX_ACC1 = 6'h03;
  localparam logic [IDX_W-1:0] IDX_ACC0 = 6'h04;
  localparam logic [IDX_W-1:0] IDX_FAULT = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_EVENT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_GENERAL = 6'h11;
  localparam logic [IDX_W-1:0] IDX_PROF_A = 6'h12;
  localparam logic [IDX_W-1:0] IDX_PROF_B = 6'h13;
  localparam logic [IDX_W-1:0] IDX_PIN = 6'h14;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h16;
  localparam logic [IDX_W-1:0] IDX_THRESH = 6'h17;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h18;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h19;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts and reset values
  localparam int CUR_W = 8;
  localparam int ACC_W = 26;
  localparam int ACC_LSB = 6;
  localparam int COND_W = 6;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int FAULT_ERR_BIT = 7;
  localparam int FAULT_DISCH_BIT = 6;
  localparam int GEN_ALERT_BIT = 5;
  localparam int GEN_ATTACH_BIT = 4;
  localparam int GEN_CHG_BIT = 3;
  localparam int GEN_EM_BIT = 2;
  localparam int PIN_ALERT_BIT = 1;
  localparam int PIN_ATTACH_BIT = 0;
  localparam int EV_W = 4;
  localparam int EV_ATTACH = 0;
  localparam int EV_REMOVE = 1;
  localparam int EV_THRESH = 2;
  localparam int EV_ERROR = 3;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [CUR_W-1:0] CUR_FULL_SCALE = 8'hff;
  localparam logic [ACC_W-1:0] THRESH_RST = 26'h3ffffff;

  ////////////////////////////////////////////////////////////////////////////
  // Scaling and timing
  localparam int CURRENT_LSB_UA = 11720;
  localparam int CHARGE_LSB_NAH = 3250;
  localparam longint CLK_HZ = 200000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = int'(CLK_HZ * TICK_PERIOD_S);

  ////////////////////////////////////////////////////////////////////////////
  // Power states of the port controller
  typedef enum logic [1:0] {
    PCM_ACTIVE,
    PCM_SLEEP,
    PCM_DETECT,
    PCM_ERROR
  } pcm_pwr_t;

endpackage

// File: src/pcm_regs.sv
`timescale 1ns/100ps
module pcm_regs #(
  parameter int TICK_CYC = pcm_pkg::TICK_CYCLES,
  parameter logic [pcm_pkg::CUR_W-1:0] CHG_LIMIT = 8'h08
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [pcm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pcm_pkg::DATA_W-1:0] avs_writedata,
  output logic [pcm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Port controller state
  input wire pcm_pkg::pcm_pwr_t pwr_state,
  input wire logic switch_on,
  input wire logic standalone,
  input wire logic [pcm_pkg::CUR_W-1:0] cur_sample,
  input wire logic cur_valid,
  // Fault and presence conditions
  input wire logic [pcm_pkg::COND_W-1:0] fault_cond,
  input wire logic disch_cond,
  input wire logic attach_sense,
  // Emulation status
  input wire logic em_active,
  input wire logic [1:0] applied_pair_field,
  input wire logic [pcm_pkg::BYTE_W-1:0] profile_a,
  input wire logic [pcm_pkg::BYTE_W-1:0] profile_b,
  // Pins and requests
  output logic alert_pin_b,
  output logic attach_output_pin_b,
  output logic recover_req,
  output logic irq
);
  import pcm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  pcm_acc_if acc_if ();
  logic [IDX_W-1:0] idx;
  logic wr_done;
  logic rd_done;
  logic wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [CUR_W-1:0] cur_r;
  pcm_pwr_t pwr_q;
  logic enter_quiet;
  logic rationing_enable_bit_r;
  logic rtn_clr_r;
  logic [ACC_W-1:0] thresh_r;
  logic [DATA_W-1:0] acc_word;
  logic err_r;
  logic disch_r;
  logic err_wr0;
  logic err_clear_ok;
  logic err_set;
  logic recover_r;
  logic [EV_W-1:0] ev_r;
  logic [EV_W-1:0] ev_en_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic attach_q;
  logic err_q;
  logic irq_r;
  logic alert_b_r;
  logic attach_b_r;
  logic [BYTE_W-1:0] fault_byte;
  logic [BYTE_W-1:0] gen_byte;
  logic [BYTE_W-1:0] pin_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // Word index from the byte address; the two low address bits are ignored
  assign idx = avs_address[IDX_LSB +: IDX_W];
  assign wr_done = avs_write && !wait_r;
  assign rd_done = avs_read && !wait_r;

  // Back-to-back requests still cost two edges each, which keeps the decode simple
  // One wait state: the request is seen, then completed on the next edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_r <= 1'b0;
    end
  end

  // Trade-off: read data stands until the next read, even across writes
  // Read data is latched while waitrequest is high, so it stands at completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (avs_read && wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  //////////////////////////////////////////////////////////////////////////////
  // Bus current value
  // Entry into a quiet state is seen against the state one cycle earlier
  assign enter_quiet = (pwr_state != pwr_q) &&
                       (pwr_state == PCM_SLEEP || pwr_state == PCM_DETECT);

  // Limitation: a sample taken while not Active is dropped, not queued
  // Clears take priority over a sample arriving in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= RST_BYTE;
      pwr_q <= PCM_SLEEP;
    end else begin
      pwr_q <= pwr_state;
      if (!switch_on) begin
        cur_r <= RST_BYTE;
      end else if (enter_quiet) begin
        cur_r <= RST_BYTE;
      end else if (pwr_state == PCM_ACTIVE && cur_valid) begin
        cur_r <= (cur_sample > CUR_FULL_SCALE) ? CUR_FULL_SCALE : cur_sample;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rationing control and charge total
  // Writing the control word with bit 1 set zeroes the total one edge later
  // Reset bit is a self-clearing pulse; it never reads back as one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rationing_enable_bit_r <= 1'b0;
      rtn_clr_r <= 1'b0;
    end else begin
      rtn_clr_r <= wr_done && (idx == IDX_CTRL) && avs_writedata[CTRL_RST_BIT];
      if (wr_done && idx == IDX_CTRL) begin
        rationing_enable_bit_r <= avs_writedata[CTRL_EN_BIT];
      end
    end
  end

  // Reset value keeps the compare quiet until software programs a level or the total saturates
  // Threshold is a full-width word so the compare never sees a torn value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thresh_r <= THRESH_RST;
    end else if (wr_done && idx == IDX_THRESH) begin
      thresh_r <= avs_writedata[ACC_W-1:0];
    end
  end

  // Accumulator sees the settled current value, never the raw sample
  assign acc_if.active = (pwr_state == PCM_ACTIVE);
  assign acc_if.rationing_enable_bit = rationing_enable_bit_r;
  assign acc_if.rtn_clr = rtn_clr_r;
  assign acc_if.sample = cur_r;
  assign acc_if.threshold = thresh_r;

  // One-second enable; a shorter count may be set for simulation
  pcm_sec_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .t(acc_if.tck)
  );

  pcm_charge_acc u_acc (
    .clk(clk),
    .rst_b(rst_b),
    .a(acc_if.acc)
  );

  // Total left-justified with the six low bits reading zero
  assign acc_word = {acc_if.total, {ACC_LSB{1'b0}}};

  //////////////////////////////////////////////////////////////////////////////
  // Error and discharge failure flags
  // Any live fault or discharge condition holds the error flag
  assign err_wr0 = wr_done && (idx == IDX_FAULT) && !avs_writedata[FAULT_ERR_BIT];
  assign err_clear_ok = err_wr0 && (fault_cond == '0) && !disch_cond;
  assign err_set = (fault_cond != '0) || disch_cond;

  // A live condition always wins over a software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
      recover_r <= 1'b0;
    end else begin
      recover_r <= err_clear_ok && err_r;
      if (err_set) begin
        err_r <= 1'b1;
      end else if (err_clear_ok) begin
        err_r <= 1'b0;
      end
    end
  end

  // Hazard: a read racing a live condition leaves the flag set
  // Discharge failure is sticky so software sees a short event
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disch_r <= 1'b0;
    end else if (disch_cond) begin
      disch_r <= 1'b1;
    end else if (err_wr0 || (rd_done && idx == IDX_FAULT)) begin
      disch_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event status, enable and interrupt
  // One-cycle history for edge detection; resets to the idle low level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      attach_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      attach_q <= attach_sense;
      err_q <= err_r;
    end
  end

  // Attach and removal edges only count in stand-alone mode
  always_comb begin
    ev_set = '0;
    ev_set[EV_ATTACH] = standalone && attach_sense && !attach_q;
    ev_set[EV_REMOVE] = standalone && !attach_sense && attach_q;
    ev_set[EV_THRESH] = acc_if.thr_hit;
    ev_set[EV_ERROR] = err_r && !err_q;
  end

  // Upper bits of the written word are ignored
  // Clearing through the clear register or writing ones to the status word
  assign ev_clr = (wr_done && (idx == IDX_IRQ_CLR || idx == IDX_EVENT)) ?
                  avs_writedata[EV_W-1:0] : '0;

  // Set wins over clear in the same cycle, bit by bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_r <= '0;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
    end
  end

  // Enable mask, same layout as the event status word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_en_r <= '0;
    end else if (wr_done && idx == IDX_IRQ_EN) begin
      ev_en_r <= avs_writedata[EV_W-1:0];
    end
  end

  // Interrupt and alert pin both follow pending enabled events
  // Only the alert pin also follows the error and discharge flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      alert_b_r <= 1'b1;
      attach_b_r <= 1'b1;
    end else begin
      irq_r <= |(ev_r & ev_en_r);
      alert_b_r <= !(|(ev_r & ev_en_r) || err_r || disch_r);
      attach_b_r <= !attach_sense;
    end
  end

  assign irq = irq_r;
  assign alert_pin_b = alert_b_r;
  assign attach_output_pin_b = attach_b_r;
  assign recover_req = recover_r;

  //////////////////////////////////////////////////////////////////////////////
  // Status bytes
  // Charging bit compares the held current, so it clears together with it
  // Pin bits read the same flops that drive the pins, so they never disagree
  always_comb begin
    fault_byte = {err_r, disch_r, fault_cond};
    gen_byte = RST_BYTE;
    gen_byte[GEN_ALERT_BIT] = !alert_b_r;
    gen_byte[GEN_ATTACH_BIT] = !attach_b_r;
    gen_byte[GEN_CHG_BIT] = cur_r > CHG_LIMIT;
    gen_byte[GEN_EM_BIT] = em_active;
    gen_byte[1:0] = applied_pair_field;
    pin_byte = RST_BYTE;
    pin_byte[PIN_ALERT_BIT] = !alert_b_r;
    pin_byte[PIN_ATTACH_BIT] = !attach_b_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped and write-only words read as zero
  // The chain is for clarity only; no two indices overlap
  always_comb begin
    rdata_nxt = '0;
    if (idx == IDX_CURRENT) begin
      rdata_nxt = DATA_W'(cur_r);
    end else if (idx == IDX_ACC3) begin
      rdata_nxt = DATA_W'(acc_word[3*BYTE_W +: BYTE_W]);
    end else if (idx == IDX_ACC2) begin
      rdata_nxt = DATA_W'(acc_word[2*BYTE_W +: BYTE_W]);
    end else if (idx == IDX_ACC1) begin
      rdata_nxt = DATA_W'(acc_word[BYTE_W +: BYTE_W]);
    end else if (idx == IDX_ACC0) begin
      rdata_nxt = DATA_W'(acc_word[0 +: BYTE_W]);
    end else if (idx == IDX_FAULT) begin
      rdata_nxt = DATA_W'(fault_byte);
    end else if (idx == IDX_EVENT) begin
      rdata_nxt = DATA_W'(ev_r);
    end else if (idx == IDX_GENERAL) begin
      rdata_nxt = DATA_W'(gen_byte);
    end else if (idx == IDX_PROF_A) begin
      rdata_nxt = DATA_W'(profile_a);
    end else if (idx == IDX_PROF_B) begin
      rdata_nxt = DATA_W'(profile_b);
    end else if (idx == IDX_PIN) begin
      rdata_nxt = DATA_W'(pin_byte);
    end else if (idx == IDX_CTRL) begin
      rdata_nxt = DATA_W'(rationing_enable_bit_r);
    end else if (idx == IDX_THRESH) begin
      rdata_nxt = DATA_W'(thresh_r);
    end else if (idx == IDX_IRQ_EN) begin
      rdata_nxt = DATA_W'(ev_en_r);
    end
  end

endmodule

// File: src/pcm_sec_tick.sv
`timescale 1ns/100ps
module pcm_sec_tick #(
  parameter int TICK_CYC = pcm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // One-second enable
  pcm_acc_if.tck t
);
  import pcm_pkg::*;

  logic [31:0] cnt_r;
  logic tick_r;

  // Divider: one enable pulse per interval, never a derived clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYC - 1)) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'd1;
      tick_r <= 1'b0;
    end
  end

  assign t.tick = tick_r;

endmodule

// File: tb/pcm_dev_model.sv
`timescale 1ns/100ps
module pcm_dev_model
  import pcm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Load drawn by the device
  input wire logic [pcm_pkg::CUR_W-1:0] draw,
  // Converted current
  output logic [pcm_pkg::CUR_W-1:0] cur_sample,
  output logic cur_valid
);
  logic [1:0] div_r;

  // One conversion every fourth cycle; the line toggles in between so stale data never matches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 2'h0;
      cur_valid <= 1'b0;
      cur_sample <= 8'h00;
    end else begin
      div_r <= div_r + 2'h1;
      cur_valid <= div_r == 2'h3;
      cur_sample <= div_r == 2'h3 ? draw : ~cur_sample;
    end
  end
endmodule

// File: tb/pcm_regs_chk.sv
`timescale 1ns/100ps
module pcm_regs_chk
  import pcm_pkg::*;
#(
  parameter int TICK_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic [pcm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pcm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [pcm_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Port state
  input wire pcm_pkg::pcm_pwr_t pwr_state,
  input wire logic switch_on,
  input wire logic [pcm_pkg::COND_W-1:0] fault_cond,
  input wire logic disch_cond,
  input wire logic attach_sense,
  // Pins
  input wire logic alert_pin_b,
  input wire logic attach_output_pin_b,
  input wire logic recover_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Completed accesses by word index
  logic [IDX_W-1:0] idx;
  logic rd_done;
  logic fix_wr;
  logic asleep;
  assign idx = avs_address[7:2];
  assign rd_done = avs_read && !avs_waitrequest;
  assign fix_wr = avs_write && !avs_waitrequest && idx == IDX_FAULT && !avs_writedata[7];
  assign asleep = pwr_state == PCM_SLEEP || pwr_state == PCM_DETECT;

  ////////////////////////////////////////////////////////////////////////////
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait length");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("stray answer");
  a_acc_pad: assert property (
    rd_done && idx == IDX_ACC0 |-> avs_readdata[5:0] == 6'h00) else $error("acc pad");
  a_cur_off_zero: assert property (
    (!switch_on [*4]) ##0 (rd_done && idx == IDX_CURRENT) |-> avs_readdata == 32'h0)
    else $error("current with switch off");
  a_cur_sleep_zero: assert property (
    (asleep [*4]) ##0 (rd_done && idx == IDX_CURRENT) |-> avs_readdata == 32'h0)
    else $error("current asleep");
  a_attach_pin: assert property (
    $past(rst_b) |-> attach_output_pin_b == !$past(attach_sense)) else $error("attach pin");
  a_recover_cause: assert property (
    $rose(recover_req) |-> $past(fix_wr) || $past(fix_wr, 2)) else $error("recover cause");
  a_recover_block: assert property (
    fix_wr && (|fault_cond || disch_cond) |=> !recover_req [*2]) else $error("recover blocked");
  a_recover_pulse: assert property (
    recover_req |=> !recover_req) else $error("recover width");
  a_fault_alert: assert property (
    |fault_cond |-> ##[1:3] !alert_pin_b) else $error("fault alert");

  // Main scenarios reached
  c_recover: cover property ($rose(recover_req));
  c_cur_read: cover property (rd_done && idx == IDX_CURRENT && avs_readdata != 32'h0);
  c_acc_read: cover property (rd_done && idx == IDX_ACC1 && avs_readdata != 32'h0);
endmodule

bind pcm_regs pcm_regs_chk #(.TICK_CYC(TICK_CYC)) pcm_regs_chk_i (
  .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .pwr_state, .switch_on, .fault_cond, .disch_cond, .attach_sense,
  .alert_pin_b, .attach_output_pin_b, .recover_req
);

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pcm_pkg::*;
  typedef struct {
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] exp;
    logic ro;
  } pcm_row_t;
  localparam int TCK = 20;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, switch_on = 1'b0;
  logic standalone = 1'b1, disch_cond = 1'b0, attach_sense = 1'b0, em_active = 1'b0;
  logic [1:0] applied_pair_field = 2'h0;
  logic [BYTE_W-1:0] profile_a = 8'h00, profile_b = 8'h00;
  logic avs_waitrequest, cur_valid, alert_pin_b, attach_output_pin_b, recover_req, irq;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata, q, t1, t2;
  logic [CUR_W-1:0] draw = 8'h00, cur_sample;
  logic [COND_W-1:0] fault_cond = 6'h00;
  pcm_pwr_t pwr_state = PCM_SLEEP;
  pcm_row_t rows [13];
  int miscompares = 0, comparisons = 0;

  // Block and attached device; short second keeps the run brief
  pcm_regs #(.TICK_CYC(TCK)) pcm_regs_i (
    .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .pwr_state, .switch_on, .standalone, .cur_sample, .cur_valid,
    .fault_cond, .disch_cond, .attach_sense, .em_active, .applied_pair_field,
    .profile_a, .profile_b, .alert_pin_b, .attach_output_pin_b,
    .recover_req, .irq
  );
  pcm_dev_model pcm_dev_model_i (.clk, .rst_b, .draw, .cur_sample, .cur_valid);

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Held until waitrequest is seen low; the spare edge keeps strobes from double assignment
  task automatic bus(input logic w, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [IDX_W-1:0] i, input string n, input logic [DATA_W-1:0] e);
    bus(1'b0, i, 32'h0);
    chk(n, q, e);
  endtask

  // Bytes are not latched together, so only read while the total is still
  task automatic rd_total(output logic [DATA_W-1:0] t);
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, IDX_ACC3 + 6'(k), 32'h0);
      t = {t[23:0], q[7:0]};
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, nearly nine times the expected run
  initial begin
    idle(6000);
    miscompares++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset, register map rows, then hand-written cases
  initial begin
    rows = '{
      '{IDX_CURRENT, 32'h0, 1'b1}, '{IDX_ACC3, 32'h0, 1'b1}, '{IDX_ACC2, 32'h0, 1'b1},
      '{IDX_ACC1, 32'h0, 1'b1}, '{IDX_ACC0, 32'h0, 1'b1}, '{IDX_FAULT, 32'h0, 1'b0},
      '{IDX_EVENT, 32'h0, 1'b1}, '{IDX_GENERAL, 32'h0, 1'b1}, '{IDX_PROF_A, 32'h0, 1'b1},
      '{IDX_PROF_B, 32'h0, 1'b1}, '{IDX_PIN, 32'h0, 1'b1}, '{IDX_THRESH, 32'h3ffffff, 1'b0},
      '{6'h3f, 32'h0, 1'b1}};
    idle(10);
    chk("rst_wait", 32'(avs_waitrequest), 32'h1);
    chk("rst_irq", 32'(irq), 32'h0);
    rst_b <= 1'b1;
    idle(1);
    foreach (rows[k]) begin
      rd(rows[k].idx, $sformatf("reg_%h", rows[k].idx), rows[k].exp);
      if (rows[k].ro) begin
        bus(1'b1, rows[k].idx, 32'hff);
        rd(rows[k].idx, $sformatf("ro_%h", rows[k].idx), rows[k].exp);
      end
    end
    $display("end map");
    draw <= CUR_FULL_SCALE;
    switch_on <= 1'b1;
    pwr_state <= PCM_ACTIVE;
    idle(10);
    rd(IDX_CURRENT, "cur_full", 32'hff);
    rd(IDX_GENERAL, "charging", 32'h08);
    switch_on <= 1'b0;
    idle(4);
    rd(IDX_CURRENT, "cur_off", 32'h0);
    switch_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pwr_state <= PCM_ACTIVE;
      idle(10);
      pwr_state <= k ? PCM_DETECT : PCM_SLEEP;
      idle(3);
      rd(IDX_CURRENT, "cur_enter", 32'h0);
    end
    $display("end current");
    draw <= 8'h05;
    bus(1'b1, IDX_CTRL, 32'h1);
    pwr_state <= PCM_ACTIVE;
    idle(100);
    pwr_state <= PCM_SLEEP;
    idle(5);
    rd_total(t1);
    idle(3 * TCK);
    rd_total(t2);
    chk("acc_hold", t2, t1);
    chk("acc_pad", 32'(t1[5:0]), 32'h0);
    chk("acc_step", 32'((t1 >> 6) % 5), 32'h0);
    chk("acc_range", 32'((t1 >> 6) >= 15 && (t1 >> 6) <= 30), 32'h1);
    pwr_state <= PCM_ACTIVE;
    idle(60);
    pwr_state <= PCM_SLEEP;
    idle(5);
    rd_total(t2);
    chk("acc_resume", 32'(t2 > t1 && ((t2 - t1) >> 6) % 5 == 0), 32'h1);
    bus(1'b1, IDX_CTRL, 32'h3);
    rd_total(t2);
    chk("acc_clr", t2, 32'h0);
    $display("end charge");
    bus(1'b1, IDX_THRESH, 32'h0a);
    pwr_state <= PCM_ACTIVE;
    idle(100);
    pwr_state <= PCM_SLEEP;
    idle(5);
    chk("irq_masked", 32'(irq), 32'h0);
    rd(IDX_EVENT, "ev_thr", 32'h4);
    bus(1'b1, IDX_IRQ_EN, 32'h4);
    idle(2);
    chk("irq_on", 32'(irq), 32'h1);
    rd(IDX_PIN, "pin_alert", 32'h2);
    bus(1'b1, IDX_IRQ_CLR, 32'h4);
    idle(2);
    chk("irq_off", 32'(irq), 32'h0);
    bus(1'b1, IDX_CTRL, 32'h0);
    rd_total(t2);
    chk("acc_dis", t2, 32'h0);
    $display("end threshold");
    fault_cond <= 6'h01;
    idle(3);
    rd(IDX_FAULT, "fault_set", 32'h81);
    bus(1'b1, IDX_FAULT, 32'h0);
    rd(IDX_FAULT, "fault_stay", 32'h81);
    fault_cond <= 6'h00;
    bus(1'b1, IDX_FAULT, 32'h0);
    rd(IDX_FAULT, "fault_clr", 32'h0);
    rd(IDX_EVENT, "ev_err", 32'h8);
    for (int k = 0; k < 2; k++) begin
      disch_cond <= 1'b1;
      idle(3);
      disch_cond <= (k == 1);
      bus(1'b0, IDX_FAULT, 32'h0);
      chk("disch_set", q & 32'h40, 32'h40);
      if (k == 1) begin
        disch_cond <= 1'b0;
        bus(1'b1, IDX_FAULT, 32'h0);
      end
      bus(1'b0, IDX_FAULT, 32'h0);
      chk("disch_gone", q & 32'h40, 32'h0);
      bus(1'b1, IDX_FAULT, 32'h0);
    end
    $display("end fault");
    bus(1'b1, IDX_EVENT, 32'hff);
    standalone <= 1'b0;
    attach_sense <= 1'b1;
    em_active <= 1'b1;
    applied_pair_field <= 2'h2;
    profile_a <= 8'h5a;
    profile_b <= 8'ha5;
    idle(3);
    rd(IDX_EVENT, "ev_gated", 32'h0);
    rd(IDX_PIN, "pin_attach", 32'h1);
    rd(IDX_GENERAL, "gen_attach", 32'h16);
    rd(IDX_PROF_A, "prof_a", 32'h5a);
    rd(IDX_PROF_B, "prof_b", 32'ha5);
    attach_sense <= 1'b0;
    idle(3);
    standalone <= 1'b1;
    attach_sense <= 1'b1;
    idle(3);
    attach_sense <= 1'b0;
    idle(3);
    rd(IDX_EVENT, "ev_attach", 32'h3);
    $display("end attach");
    bus(1'b1, IDX_IRQ_EN, 32'h3);
    idle(2);
    chk("irq_ev", 32'(irq), 32'h1);
    rst_b <= 1'b0;
    idle(2);
    chk("rst2_irq", 32'(irq), 32'h0);
    chk("rst2_alert", 32'(alert_pin_b), 32'h1);
    rst_b <= 1'b1;
    idle(1);
    rd(IDX_EVENT, "rst2_ev", 32'h0);
    rd(IDX_IRQ_EN, "rst2_en", 32'h0);
    $display("end reset");
    end_of_test();
  end
endmodule
